/* logic/xtr_expert_map.vh */
/*
 * Register offsets, field positions, reset values and timing figures of the
 * expert tuning register bank.
 * Assumes nothing of its surroundings; definitions only.
 */
`ifndef XTR_EXPERT_MAP_VH
`define XTR_EXPERT_MAP_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define XTR_ADDR_STARTUP_PLL   8'h32
`define XTR_ADDR_DEMOD_RSSI    8'h33

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define XTR_RST_STARTUP_PLL    8'h48
`define XTR_RST_DEMOD_RSSI     8'h02

// ----------------------------------------------------------------------
// Fields of startup_pll_tuning
// ----------------------------------------------------------------------
`define XTR_OSC_DLY_HI         7
`define XTR_OSC_DLY_LO         6
`define XTR_ASK_MID_BIT        5
`define XTR_FRAC_DIS_BIT       2
`define XTR_LOCK_DLY_HI        1
`define XTR_LOCK_DLY_LO        0

// ----------------------------------------------------------------------
// Fields of demod_rssi_tuning
// ----------------------------------------------------------------------
`define XTR_DUAL_LIM_BIT       7
`define XTR_WIDE_FM_BIT        6
`define XTR_EDGE_WIN_BIT       5
`define XTR_SHORT_TMO_BIT      4
`define XTR_RSSI_MSB_BIT       3
`define XTR_RSSI_FAST_BIT      2
`define XTR_CAP_HI             1
`define XTR_CAP_LO             0

// ----------------------------------------------------------------------
// Timing: step sizes in microseconds and clock rate
// ----------------------------------------------------------------------
`define XTR_CLK_MHZ            10
`define XTR_OSC_STEP_US        256
`define XTR_LOCK_STEP_US       16

// ----------------------------------------------------------------------
// Demodulator delay element counts, per select code
// ----------------------------------------------------------------------
`define XTR_DLY_EL_00          6'h28
`define XTR_DLY_EL_01          6'h0d
`define XTR_DLY_EL_10          6'h14
`define XTR_DLY_EL_11          6'h07

// ----------------------------------------------------------------------
// Timeout in half chips, RSSI bit clocks, settle time constants
// ----------------------------------------------------------------------
`define XTR_TMO_LONG_HALF      3'h7
`define XTR_TMO_SHORT_HALF     3'h5
`define XTR_B5_CLK_SLOW        2'h3
`define XTR_B5_CLK_EVEN        2'h2
`define XTR_B4_CLK_FAST        2'h1
`define XTR_B4_CLK_EVEN        2'h2
`define XTR_SETTLE_TC_SLOW     3'h4
`define XTR_SETTLE_TC_FAST     3'h2

`endif

/* logic/xtr_expert_regs.v */
/*
 * Expert tuning register bank: two byte registers written and read over the
 * serial control port's internal register strobes, the startup delay
 * sequencer that they steer, and decoded tuning controls for the PLL,
 * ASK baseband filter, FM demodulator and RSSI converter.
 * Assumes the serial decoder gives synchronous one-cycle strobes and that
 * oscillator-ready and raw PLL lock are synchronous levels.
 */
// Notes on behaviour
// - Two-bit code sets wait after oscillator ready: 256, 512, 768, 1024 us; reset 01.
// - ASK only: baseband filter restarts from zero, or from RSSI mid-range if set.
// - Fractional-PLL disable bit forces integer-only synthesizer division.
// - Two-bit code adds 16, 32, 48 or 64 us after raw PLL lock.
// - Dual-limiter bit makes FSK demodulator use both I and Q limiters.
// - Wide-range bit: clear 200-400 kHz, set 0-600 kHz demodulator input range.
// - Both demodulator bits pick delay line length: 40, 13, 20, 7 elements.
// - Edge window bit: clear uses samples -1,+1; set uses -2,-1,+1,+2.
// - Chip timing check times out after 3.5 chips, or 2.5 when set.
// - RSSI top bits: 3 and 1 clocks when clear, 2 and 2 when set.
// - RSSI settling lasts four time constants, or two when fast bit set.
`timescale 1ns/10ps
`include "xtr_expert_map.vh"

module xtr_expert_regs #(
  parameter OSC_STEP_CYC  = `XTR_OSC_STEP_US * `XTR_CLK_MHZ,
  parameter LOCK_STEP_CYC = `XTR_LOCK_STEP_US * `XTR_CLK_MHZ
) (
  input  wire       clock,
  input  wire       rstn,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  output reg        reg_rvalid,
  input  wire       startup_req,
  input  wire       osc_ready_flag,
  input  wire       pll_lock_raw,
  input  wire       ask_mode,
  output reg        osc_settled,
  output reg        pll_lock_reported,
  output reg        bb_reset_to_mid,
  output reg        frac_pll_disable,
  output reg        fm_dual_limiter_sel,
  output reg        wide_fm_range_sel,
  output reg  [5:0] demod_delay_elements,
  output reg        edge_window_width_sel,
  output reg  [2:0] chip_timeout_half_chips,
  output reg  [1:0] rssi_bit5_clocks,
  output reg  [1:0] rssi_bit4_clocks,
  output reg  [2:0] rssi_settle_tc,
  output reg  [1:0] rssi_filter_cap_sel
);

  // ----------------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------------
  localparam ST_IDLE      = 3'h0;
  localparam ST_OSC_WAIT  = 3'h1;
  localparam ST_OSC_DLY   = 3'h2;
  localparam ST_LOCK_WAIT = 3'h3;
  localparam ST_LOCK_DLY  = 3'h4;
  localparam ST_DONE      = 3'h5;

  reg  [7:0]  startup_pll_tuning_r;
  reg  [7:0]  demod_rssi_tuning_r;
  reg  [2:0]  state_r;
  reg  [2:0]  state_nxt;
  reg  [1:0]  osc_code_r;
  reg  [1:0]  lock_code_r;
  reg  [15:0] cnt_r;
  reg  [15:0] cnt_nxt;

  // Wait length in cycles for a two-bit code: (code + 1) steps
  function [15:0] xtr_delay_cycles;
    input [1:0]  code;
    input [31:0] step;
    reg   [31:0] prod;
    begin
      prod = ({30'h0, code} + 32'h1) * step;
      xtr_delay_cycles = prod[15:0];
    end
  endfunction

  // Delay line length for the two demodulator select bits
  function [5:0] xtr_delay_elements;
    input [1:0] sel;
    begin
      case (sel)
        2'h0:    xtr_delay_elements = `XTR_DLY_EL_00;
        2'h1:    xtr_delay_elements = `XTR_DLY_EL_01;
        2'h2:    xtr_delay_elements = `XTR_DLY_EL_10;
        default: xtr_delay_elements = `XTR_DLY_EL_11;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------

  // Byte writes at the two documented offsets; other offsets ignored
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      startup_pll_tuning_r <= `XTR_RST_STARTUP_PLL;
      demod_rssi_tuning_r  <= `XTR_RST_DEMOD_RSSI;
    end else if (reg_wr) begin
      if (reg_addr == `XTR_ADDR_STARTUP_PLL)
        startup_pll_tuning_r <= reg_wdata;
      if (reg_addr == `XTR_ADDR_DEMOD_RSSI)
        demod_rssi_tuning_r <= reg_wdata;
    end
  end

  // Registered read answer, one cycle after the strobe; unmapped reads zero
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        case (reg_addr)
          `XTR_ADDR_STARTUP_PLL: reg_rdata <= startup_pll_tuning_r;
          `XTR_ADDR_DEMOD_RSSI:  reg_rdata <= demod_rssi_tuning_r;
          default:               reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Startup delay sequencer
  // ----------------------------------------------------------------------

  // Next state and counter; dropping the request returns to idle
  always @* begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      ST_IDLE: begin
        if (startup_req)
          state_nxt = ST_OSC_WAIT;
      end
      ST_OSC_WAIT: begin
        if (osc_ready_flag) begin
          state_nxt = ST_OSC_DLY;
          cnt_nxt   = xtr_delay_cycles(osc_code_r, OSC_STEP_CYC) - 16'h1;
        end
      end
      ST_OSC_DLY: begin
        if (cnt_r == 16'h0)
          state_nxt = ST_LOCK_WAIT;
        else
          cnt_nxt = cnt_r - 16'h1;
      end
      ST_LOCK_WAIT: begin
        if (pll_lock_raw) begin
          state_nxt = ST_LOCK_DLY;
          cnt_nxt   = xtr_delay_cycles(lock_code_r, LOCK_STEP_CYC) - 16'h1;
        end
      end
      ST_LOCK_DLY: begin
        if (!pll_lock_raw)
          state_nxt = ST_LOCK_WAIT;   // Lock lost: restart the extra wait
        else if (cnt_r == 16'h0)
          state_nxt = ST_DONE;
        else
          cnt_nxt = cnt_r - 16'h1;
      end
      ST_DONE: begin
        state_nxt = ST_DONE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    if (!startup_req) begin
      state_nxt = ST_IDLE;
      cnt_nxt   = 16'h0;
    end
  end

  // State, counter and delay codes captured when a sequence starts
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_r     <= ST_IDLE;
      cnt_r       <= 16'h0;
      osc_code_r  <= 2'h1;
      lock_code_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      if (state_r == ST_IDLE && startup_req) begin
        osc_code_r  <= startup_pll_tuning_r[`XTR_OSC_DLY_HI:`XTR_OSC_DLY_LO];
        lock_code_r <= startup_pll_tuning_r[`XTR_LOCK_DLY_HI:`XTR_LOCK_DLY_LO];
      end
    end
  end

  // Sequencer milestones
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      osc_settled       <= 1'b0;
      pll_lock_reported <= 1'b0;
    end else begin
      osc_settled       <= (state_nxt == ST_LOCK_WAIT) || (state_nxt == ST_LOCK_DLY) ||
                           (state_nxt == ST_DONE);
      pll_lock_reported <= (state_nxt == ST_DONE);
    end
  end

  // ----------------------------------------------------------------------
  // Decoded tuning controls
  // ----------------------------------------------------------------------

  // Each control registered from the tuning bytes
  always @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      bb_reset_to_mid         <= 1'b0;
      frac_pll_disable        <= 1'b0;
      fm_dual_limiter_sel     <= 1'b0;
      wide_fm_range_sel       <= 1'b0;
      demod_delay_elements    <= `XTR_DLY_EL_00;
      edge_window_width_sel   <= 1'b0;
      chip_timeout_half_chips <= `XTR_TMO_LONG_HALF;
      rssi_bit5_clocks        <= `XTR_B5_CLK_SLOW;
      rssi_bit4_clocks        <= `XTR_B4_CLK_FAST;
      rssi_settle_tc          <= `XTR_SETTLE_TC_SLOW;
      rssi_filter_cap_sel     <= 2'h2;
    end else begin
      bb_reset_to_mid       <= ask_mode & startup_pll_tuning_r[`XTR_ASK_MID_BIT];
      frac_pll_disable      <= startup_pll_tuning_r[`XTR_FRAC_DIS_BIT];
      fm_dual_limiter_sel   <= demod_rssi_tuning_r[`XTR_DUAL_LIM_BIT];
      wide_fm_range_sel     <= demod_rssi_tuning_r[`XTR_WIDE_FM_BIT];
      demod_delay_elements  <= xtr_delay_elements(
                                 demod_rssi_tuning_r[`XTR_DUAL_LIM_BIT:`XTR_WIDE_FM_BIT]);
      edge_window_width_sel <= demod_rssi_tuning_r[`XTR_EDGE_WIN_BIT];
      chip_timeout_half_chips <= demod_rssi_tuning_r[`XTR_SHORT_TMO_BIT] ?
                                 `XTR_TMO_SHORT_HALF : `XTR_TMO_LONG_HALF;
      rssi_bit5_clocks      <= demod_rssi_tuning_r[`XTR_RSSI_MSB_BIT] ?
                               `XTR_B5_CLK_EVEN : `XTR_B5_CLK_SLOW;
      rssi_bit4_clocks      <= demod_rssi_tuning_r[`XTR_RSSI_MSB_BIT] ?
                               `XTR_B4_CLK_EVEN : `XTR_B4_CLK_FAST;
      rssi_settle_tc        <= demod_rssi_tuning_r[`XTR_RSSI_FAST_BIT] ?
                               `XTR_SETTLE_TC_FAST : `XTR_SETTLE_TC_SLOW;
      rssi_filter_cap_sel   <= demod_rssi_tuning_r[`XTR_CAP_HI:`XTR_CAP_LO];
    end
  end

endmodule

/* dv/xtr_expert_sva.sv */
/* Checker of the expert tuning bank ports.
   Assumes it is bound to xtr_expert_regs and sees only its ports. */
`timescale 1ns/10ps
module xtr_expert_sva (
  input logic       clock,
  input logic       rstn,
  input logic [7:0] reg_addr,
  input logic [7:0] reg_wdata,
  input logic       reg_wr,
  input logic       reg_rd,
  input logic       reg_rvalid,
  input logic       startup_req,
  input logic       ask_mode,
  input logic       osc_settled,
  input logic       pll_lock_reported,
  input logic       bb_reset_to_mid,
  input logic       frac_pll_disable,
  input logic       fm_dual_limiter_sel,
  input logic [5:0] demod_delay_elements,
  input logic [2:0] chip_timeout_half_chips
);
  // ---------------------------------------------
  // Properties
  // ---------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  // Write strobes aimed at each register
  wire w32 = reg_wr && reg_addr == 8'h32;
  wire w33 = reg_wr && reg_addr == 8'h33;
  property p_rv; reg_rd |=> reg_rvalid; endproperty
  a_rv: assert property (p_rv) else $error("read not answered");
  property p_rv_only; !reg_rd |=> !reg_rvalid; endproperty
  a_rv_only: assert property (p_rv_only) else $error("spurious read valid");
  property p_frac; w32 |=> ##1 frac_pll_disable == $past(reg_wdata[2], 2); endproperty
  a_frac: assert property (p_frac) else $error("frac disable wrong");
  property p_dual; w33 |=> ##1 fm_dual_limiter_sel == $past(reg_wdata[7], 2); endproperty
  a_dual: assert property (p_dual) else $error("dual limiter wrong");
  property p_dly; w33 && reg_wdata[7:6] == 2'h3 |=> ##1 demod_delay_elements == 6'h07;
  endproperty
  a_dly: assert property (p_dly) else $error("delay line length wrong");
  property p_tmo; w33 && reg_wdata[4] |=> ##1 chip_timeout_half_chips == 3'h5; endproperty
  a_tmo: assert property (p_tmo) else $error("short timeout wrong");
  property p_bb; !ask_mode |=> !bb_reset_to_mid; endproperty
  a_bb: assert property (p_bb) else $error("mid reset outside ask");
  property p_drop; !startup_req |=> ##1 !osc_settled && !pll_lock_reported; endproperty
  a_drop: assert property (p_drop) else $error("startup levels held");
  property p_ord; pll_lock_reported |-> osc_settled; endproperty
  a_ord: assert property (p_ord) else $error("lock before oscillator");
  c_rd: cover property (reg_rd ##1 reg_rvalid);
  c_lock: cover property ($rose(pll_lock_reported));
  c_bb: cover property (bb_reset_to_mid);
endmodule
bind xtr_expert_regs xtr_expert_sva u_sva (.clock, .rstn, .reg_addr, .reg_wdata, .reg_wr,
  .reg_rd, .reg_rvalid, .startup_req, .ask_mode, .osc_settled, .pll_lock_reported,
  .bb_reset_to_mid, .frac_pll_disable, .fm_dual_limiter_sel, .demod_delay_elements,
  .chip_timeout_half_chips);

/* dv/xtr_mcu_model.sv */
/* Microcontroller side of the register strobe port.
   Assumes strobes are taken on the rising clock edge. */
`timescale 1ns/10ps
module xtr_mcu_model (
  input  logic       clock,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic       reg_wr,
  output logic       reg_rd,
  input  logic [7:0] reg_rdata,
  input  logic       reg_rvalid
);
  // Idle bus from time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end
  // One-cycle write; released lines show inverted data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #5;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'h1;
    @(posedge clock);
    #5;
    reg_wr = 1'h0;
    reg_wdata = ~d;
    reg_addr = ~a;
  endtask
  // One-cycle read; answer collected once settled
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
    @(posedge clock);
    #5;
    reg_addr = a;
    reg_rd = 1'h1;
    @(posedge clock);
    #5;
    reg_rd = 1'h0;
    reg_addr = ~a;
    ok = reg_rvalid;
    d = reg_rdata;
  endtask
endmodule

/* dv/xtr_expert_regs_tb.sv */
/* Self-checking bench of the expert tuning bank.
   Assumes short delay steps of 4 and 2 cycles. */
`timescale 1ns/10ps
module xtr_expert_regs_tb;
  logic       clock = 1'h0;
  logic       rstn = 1'h0;
  logic       startup_req = 1'h0;
  logic       osc_ready_flag = 1'h0;
  logic       pll_lock_raw = 1'h0;
  logic       ask_mode = 1'h0;
  wire  [7:0] reg_addr, reg_wdata, reg_rdata;
  wire        reg_wr, reg_rd, reg_rvalid, osc_settled, pll_lock_reported, bb_reset_to_mid;
  wire        frac_pll_disable, fm_dual_limiter_sel, wide_fm_range_sel, edge_window_width_sel;
  wire  [5:0] demod_delay_elements;
  wire  [2:0] chip_timeout_half_chips, rssi_settle_tc;
  wire  [1:0] rssi_bit5_clocks, rssi_bit4_clocks, rssi_filter_cap_sel;
  int         errors = 0;
  int         n_compared = 0;
  logic [7:0] dv [4] = '{8'h3c, 8'h40, 8'ha4, 8'hdb};
  logic [5:0] el [4] = '{6'h28, 6'h0d, 6'h14, 6'h07};
  // ---------------------------------------------
  // Clock, design and partner
  // ---------------------------------------------
  always #50 clock = ~clock;
  xtr_expert_regs #(.OSC_STEP_CYC(4), .LOCK_STEP_CYC(2)) DUT (.clock, .rstn, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .startup_req, .osc_ready_flag,
    .pll_lock_raw, .ask_mode, .osc_settled, .pll_lock_reported, .bb_reset_to_mid,
    .frac_pll_disable, .fm_dual_limiter_sel, .wide_fm_range_sel, .demod_delay_elements,
    .edge_window_width_sel, .chip_timeout_half_chips, .rssi_bit5_clocks, .rssi_bit4_clocks,
    .rssi_settle_tc, .rssi_filter_cap_sel);
  xtr_mcu_model u_mcu (.clock, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .reg_rvalid);
  // ---------------------------------------------
  // Helpers
  // ---------------------------------------------
  task tick; @(posedge clock); #5; endtask
  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask
  task chk_n(input int got, input int exp, input string m); chk(got, exp, m); endtask
  task rdc(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic       ok;
    u_mcu.rd(a, d, ok);
    chk(ok, 1'h1, "read valid");
    chk(d, exp, "read data");
  endtask
  task report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task t_reset;
    rdc(8'h32, 8'h48);
    rdc(8'h33, 8'h02);
    chk(demod_delay_elements, 6'h28, "elements");
    chk(chip_timeout_half_chips, 3'h7, "timeout");
    chk({rssi_bit5_clocks, rssi_bit4_clocks}, 4'hd, "rssi clocks");
    chk(rssi_settle_tc, 3'h4, "settle");
    $display("t_reset done");
  endtask
  task t_decode;
    for (int i = 0; i < 4; i++) begin
      u_mcu.wr(8'h33, dv[i]);
      tick;
      chk(fm_dual_limiter_sel, dv[i][7], "dual");
      chk(wide_fm_range_sel, dv[i][6], "wide");
      chk(demod_delay_elements, el[dv[i][7:6]], "elements");
      chk(edge_window_width_sel, dv[i][5], "edge");
      chk(chip_timeout_half_chips, dv[i][4] ? 3'h5 : 3'h7, "timeout");
      chk({rssi_bit5_clocks, rssi_bit4_clocks}, dv[i][3] ? 4'ha : 4'hd, "rssi");
      chk(rssi_settle_tc, dv[i][2] ? 3'h2 : 3'h4, "settle");
      chk(rssi_filter_cap_sel, dv[i][1:0], "cap");
      rdc(8'h33, dv[i]);
    end
    u_mcu.wr(8'h40, 8'hff);
    rdc(8'h40, 8'h00);
    rdc(8'h33, 8'hdb);
    $display("t_decode done");
  endtask
  task t_ask;
    u_mcu.wr(8'h32, 8'h2c);
    tick;
    chk(frac_pll_disable, 1'h1, "frac");
    chk(bb_reset_to_mid, 1'h0, "mid reset");
    ask_mode = 1'h1;
    tick;
    chk(bb_reset_to_mid, 1'h1, "mid reset");
    u_mcu.wr(8'h32, 8'h08);
    tick;
    chk(bb_reset_to_mid, 1'h0, "mid reset");
    chk(frac_pll_disable, 1'h0, "frac");
    ask_mode = 1'h0;
    $display("t_ask done");
  endtask
  task t_startup;
    int n;
    for (int c = 0; c < 4; c++) begin
      u_mcu.wr(8'h32, {c[1:0], 4'h2, c[1:0]});
      startup_req = 1'h1;
      tick;
      u_mcu.wr(8'h32, {~c[1:0], 4'h2, ~c[1:0]});
      osc_ready_flag = 1'h1;
      n = 0;
      while (osc_settled !== 1'h1 && n < 100) begin tick; n++; end
      chk_n(n, (c + 1) * 4 + 1, "osc delay");
      pll_lock_raw = 1'h1;
      n = 0;
      while (pll_lock_reported !== 1'h1 && n < 100) begin tick; n++; end
      chk_n(n, (c + 1) * 2 + 1, "lock delay");
      startup_req = 1'h0;
      tick;
      tick;
      chk({osc_settled, pll_lock_reported}, 2'h0, "abort");
      osc_ready_flag = 1'h0;
      pll_lock_raw = 1'h0;
    end
    $display("t_startup done");
  endtask
  // Lock loss restarts the extra wait; a reset in mid-run restores defaults
  task t_relock;
    int n;
    u_mcu.wr(8'h32, 8'h09);
    startup_req = 1'h1;
    osc_ready_flag = 1'h1;
    n = 0;
    while (osc_settled !== 1'h1 && n < 100) begin tick; n++; end
    chk_n(n, 1 * 4 + 2, "osc delay ready at start");
    pll_lock_raw = 1'h1;
    tick;
    tick;
    pll_lock_raw = 1'h0;
    tick;
    pll_lock_raw = 1'h1;
    n = 0;
    while (pll_lock_reported !== 1'h1 && n < 100) begin tick; n++; end
    chk_n(n, 2 * 2 + 1, "relock delay");
    rstn = 1'h0;
    tick;
    chk({osc_settled, pll_lock_reported}, 2'h0, "levels in reset");
    chk({demod_delay_elements, chip_timeout_half_chips}, {6'h28, 3'h7}, "decode in reset");
    rstn = 1'h1;
    n = 0;
    while (osc_settled !== 1'h1 && n < 100) begin tick; n++; end
    chk_n(n, 2 * 4 + 2, "osc delay after reset");
    n = 0;
    while (pll_lock_reported !== 1'h1 && n < 100) begin tick; n++; end
    chk_n(n, 1 * 2 + 1, "lock delay after reset");
    rdc(8'h33, 8'h02);
    startup_req = 1'h0;
    osc_ready_flag = 1'h0;
    pll_lock_raw = 1'h0;
    tick;
    tick;
    $display("t_relock done");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge clock);
    #5;
    rstn = 1'h1;
    t_reset;
    t_decode;
    t_ask;
    t_startup;
    t_relock;
    report_and_stop;
  end
  // Watchdog well past the expected few hundred cycles
  initial begin
    #500000;
    errors++;
    report_and_stop;
  end
endmodule
